// ### design/ect_channel.sv
`timescale 1ns/1ps
`default_nettype none
module ect_channel
  import ect_pkg::*;
(
  input  wire logic          ref_clk_in,
  input  wire logic          sys_rst_in,
  input  wire ect_ctrl_type  ctrl_in,
  input  wire logic          ctrl_wr_in,
  input  wire logic          tick_in,
  input  wire logic          hit_in,
  output logic [7:0]         count_out,
  output logic               match_irq_out,
  output logic               wave_out
);

  logic [7:0] count_reg;
  logic       ff_reg;
  logic       irq_reg;
  logic       ovf;

  assign ovf = tick_in && (count_reg == 8'hFF);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !ctrl_in.run) begin
      count_reg <= 8'h00;
    end else if (hit_in && !ctrl_in.pwm) begin
      count_reg <= 8'h00;
    end else if (tick_in) begin
      count_reg <= count_reg + 8'h01;                   // Wraps past FF
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ctrl_in.run && hit_in;
    end
  end

  // ----------------------------------------------------------------
  // Output flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ff_reg <= 1'b0;
    end else if (ctrl_wr_in && ctrl_in.ff_set && !ctrl_in.ff_clr) begin
      ff_reg <= 1'b1;
    end else if (ctrl_wr_in && ctrl_in.ff_clr && !ctrl_in.ff_set) begin
      ff_reg <= 1'b0;
    end else if (ctrl_in.pwm) begin
      // Stopped PWM holds the inactive level
      if (!ctrl_in.run || (ctrl_in.run && hit_in)) begin
        ff_reg <= 1'b0;
      end else if (ovf) begin
        ff_reg <= 1'b1;
      end
    end else if (ctrl_in.run && hit_in && ctrl_in.lvl_inv) begin
      ff_reg <= !ff_reg;
    end
  end

  assign count_out     = count_reg;
  assign match_irq_out = irq_reg;
  assign wave_out      = ctrl_in.pwm ? (ff_reg ^ ctrl_in.lvl_inv) : ff_reg;

endmodule : ect_channel
`default_nettype wire

// ### design/ect_pkg.sv
package ect_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_DIR  = 16'hFF20;
  localparam logic [15:0] ADDR_TMC_A     = 16'hFF70;
  localparam logic [15:0] ADDR_TCL_A     = 16'hFF71;
  localparam logic [15:0] ADDR_TMC_B     = 16'hFF74;
  localparam logic [15:0] ADDR_TCL_B     = 16'hFF75;
  localparam logic [15:0] ADDR_CMP_A     = 16'hFF6A;
  localparam logic [15:0] ADDR_CNT_A     = 16'hFF6B;
  localparam logic [15:0] ADDR_CMP_B     = 16'hFF6C;
  localparam logic [15:0] ADDR_CNT_B     = 16'hFF6D;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_PORT_DIR   = 8'hFF;
  localparam logic [7:0]  RST_TMC        = 8'h00;
  localparam logic [7:0]  RST_TCL        = 8'h00;
  localparam logic [7:0]  RST_CMP        = 8'h00;

  // ----------------------------------------------------------------
  // Mode control field positions
  // ----------------------------------------------------------------
  localparam int          BIT_RUN        = 7;
  localparam int          BIT_PWM        = 6;
  localparam int          BIT_CASCADE    = 4;
  localparam int          BIT_FF_SET     = 3;
  localparam int          BIT_FF_CLR     = 2;
  localparam int          BIT_LVL_INV    = 1;
  localparam int          BIT_DRIVE_EN   = 0;
  localparam logic [7:0]  TMC_A_RD_MASK  = 8'hC3;
  localparam logic [7:0]  TMC_B_RD_MASK  = 8'hD3;
  localparam logic [7:0]  TCL_MASK       = 8'h07;

  // ----------------------------------------------------------------
  // Count clock selections and divider
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEL_EXT_FALL   = 3'h0;
  localparam logic [2:0]  SEL_EXT_RISE   = 3'h1;
  localparam logic [2:0]  SEL_DIV1       = 3'h2;
  localparam logic [2:0]  SEL_DIV2       = 3'h3;
  localparam logic [2:0]  SEL_DIV8       = 3'h4;
  localparam logic [2:0]  SEL_DIV32      = 3'h5;
  localparam logic [2:0]  SEL_DIV128     = 3'h6;
  localparam logic [2:0]  SEL_TOP        = 3'h7;
  localparam int          DIV_BITS       = 12;
  localparam int          LOG_DIV2       = 1;
  localparam int          LOG_DIV8       = 3;
  localparam int          LOG_DIV32      = 5;
  localparam int          LOG_DIV128     = 7;
  localparam int          LOG_TOP_A      = 9;
  localparam int          LOG_TOP_B      = 12;

  localparam int          PIN_A          = 6;
  localparam int          PIN_B          = 7;

  typedef struct packed {
    logic run;
    logic pwm;
    logic ff_set;
    logic ff_clr;
    logic lvl_inv;
    logic drive_en;
  } ect_ctrl_type;

endpackage : ect_pkg

// ### design/ect_timer.sv
// What this block does
// - Drive enable routes output flip-flop to pin
// - Bit one: PWM polarity, else toggle enable
// - Set/clear strobes force flip-flop; never both
// - Set/clear strobes always read back zero
// - Cascade bit chains counters into sixteen bits
// - Mode bit: clear-and-start or PWM
// - Run low stops and zeroes count
// - Reset zeroes second mode control register
// - Direction bits: zero drives, reset all ones
// - Match clears count outside PWM, continues, raises interrupt
// - Interval equals compare plus one ticks outside PWM; 256 ticks in PWM
// - Event mode counts chosen external edge
// - Prescaler taps one through top divide
// - Compare registers reset zero, byte writes
// - Lowered compare wraps through overflow first
`timescale 1ns/1ps
`default_nettype none
module ect_timer
  import ect_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic [7:0]  port_latch_in,
  input  wire logic [7:0]  port_pin_in,
  output logic [7:0]       port_pin_out,
  output logic [7:0]       port_pin_oe_out,
  output logic             match_irq_a_out,
  output logic             match_irq_b_out
);

  logic [7:0]          port_dir_reg;
  logic [7:0]          mode_a_reg;
  logic [7:0]          mode_b_reg;
  logic [2:0]          sel_a_reg;
  logic [2:0]          sel_b_reg;
  logic [7:0]          cmp_a_reg;
  logic [7:0]          cmp_b_reg;
  logic [7:0]          rdata_reg;
  logic [DIV_BITS-1:0] div_reg;
  logic [1:0]          sync_a_reg;
  logic [1:0]          sync_b_reg;
  logic                last_a_reg;
  logic                last_b_reg;
  logic                wr_mode_a_reg;
  logic                wr_mode_b_reg;
  logic [7:0]          ff_strobe_a_reg;
  logic [7:0]          ff_strobe_b_reg;
  logic [7:0]          count_a;
  logic [7:0]          count_b;
  logic                tick_a;
  logic                tick_b;
  logic                hit_a;
  logic                hit_b;
  logic                cascade;
  logic                wave_a;
  logic                wave_b;
  logic                irq_a;
  logic                irq_b;
  ect_ctrl_type        ctrl_a;
  ect_ctrl_type        ctrl_b;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      port_dir_reg <= RST_PORT_DIR;
    end else if (reg_wr_in && reg_addr_in == ADDR_PORT_DIR) begin
      port_dir_reg <= reg_wdata_in;
    end
  end

  // Strobe bits are not stored; only their one-cycle effect remains
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mode_a_reg <= RST_TMC;
      mode_b_reg <= RST_TMC;
    end else if (reg_wr_in && reg_addr_in == ADDR_TMC_A) begin
      mode_a_reg <= reg_wdata_in & TMC_A_RD_MASK;
    end else if (reg_wr_in && reg_addr_in == ADDR_TMC_B) begin
      mode_b_reg <= reg_wdata_in & TMC_B_RD_MASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_mode_a_reg   <= 1'b0;
      wr_mode_b_reg   <= 1'b0;
      ff_strobe_a_reg <= 8'h00;
      ff_strobe_b_reg <= 8'h00;
    end else begin
      wr_mode_a_reg   <= reg_wr_in && reg_addr_in == ADDR_TMC_A;
      wr_mode_b_reg   <= reg_wr_in && reg_addr_in == ADDR_TMC_B;
      ff_strobe_a_reg <= reg_wdata_in;
      ff_strobe_b_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sel_a_reg <= RST_TCL[2:0];
      sel_b_reg <= RST_TCL[2:0];
    end else if (reg_wr_in && reg_addr_in == ADDR_TCL_A) begin
      sel_a_reg <= reg_wdata_in[2:0];
    end else if (reg_wr_in && reg_addr_in == ADDR_TCL_B) begin
      sel_b_reg <= reg_wdata_in[2:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cmp_a_reg <= RST_CMP;
      cmp_b_reg <= RST_CMP;
    end else if (reg_wr_in && reg_addr_in == ADDR_CMP_A) begin
      cmp_a_reg <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == ADDR_CMP_B) begin
      cmp_b_reg <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_PORT_DIR: rdata_reg <= port_dir_reg;
        ADDR_TMC_A:    rdata_reg <= mode_a_reg;
        ADDR_TMC_B:    rdata_reg <= mode_b_reg;
        ADDR_TCL_A:    rdata_reg <= {5'h00, sel_a_reg};
        ADDR_TCL_B:    rdata_reg <= {5'h00, sel_b_reg};
        ADDR_CMP_A:    rdata_reg <= cmp_a_reg;
        ADDR_CMP_B:    rdata_reg <= cmp_b_reg;
        ADDR_CNT_A:    rdata_reg <= count_a;
        ADDR_CNT_B:    rdata_reg <= count_b;
        default:       rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Prescaler and event inputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // Second stage alone feeds the edge detector
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sync_a_reg <= 2'b00;
      sync_b_reg <= 2'b00;
      last_a_reg <= 1'b0;
      last_b_reg <= 1'b0;
    end else begin
      sync_a_reg <= {sync_a_reg[0], port_pin_in[PIN_A]};
      sync_b_reg <= {sync_b_reg[0], port_pin_in[PIN_B]};
      last_a_reg <= sync_a_reg[1];
      last_b_reg <= sync_b_reg[1];
    end
  end

  function automatic logic pick_tick(input logic [2:0] sel, input logic cur, input logic last,
                                     input logic [DIV_BITS-1:0] div, input int top_log);
    logic res;
    res = 1'b0;
    unique case (sel)
      SEL_EXT_FALL: res = last && !cur;
      SEL_EXT_RISE: res = !last && cur;
      SEL_DIV1:     res = 1'b1;
      SEL_DIV2:     res = &div[LOG_DIV2-1:0];
      SEL_DIV8:     res = &div[LOG_DIV8-1:0];
      SEL_DIV32:    res = &div[LOG_DIV32-1:0];
      SEL_DIV128:   res = &div[LOG_DIV128-1:0];
      SEL_TOP:      res = (top_log == LOG_TOP_A) ? &div[LOG_TOP_A-1:0] : &div;
    endcase
    return res;
  endfunction : pick_tick

  // ----------------------------------------------------------------
  // Counting and match
  // ----------------------------------------------------------------
  assign cascade = mode_b_reg[BIT_CASCADE];
  assign tick_a  = pick_tick(sel_a_reg, sync_a_reg[1], last_a_reg, div_reg, LOG_TOP_A);
  assign tick_b  = cascade ? (tick_a && count_a == 8'hFF && !hit_a)
                           : pick_tick(sel_b_reg, sync_b_reg[1], last_b_reg, div_reg, LOG_TOP_B);
  assign hit_a   = tick_a && (cascade ? ({count_b, count_a} == {cmp_b_reg, cmp_a_reg})
                                      : (count_a == cmp_a_reg));
  assign hit_b   = cascade ? hit_a : (tick_b && count_b == cmp_b_reg);

  assign ctrl_a = '{run: mode_a_reg[BIT_RUN], pwm: mode_a_reg[BIT_PWM],
                    ff_set: ff_strobe_a_reg[BIT_FF_SET], ff_clr: ff_strobe_a_reg[BIT_FF_CLR],
                    lvl_inv: mode_a_reg[BIT_LVL_INV], drive_en: mode_a_reg[BIT_DRIVE_EN]};
  assign ctrl_b = '{run: mode_b_reg[BIT_RUN], pwm: mode_b_reg[BIT_PWM],
                    ff_set: ff_strobe_b_reg[BIT_FF_SET], ff_clr: ff_strobe_b_reg[BIT_FF_CLR],
                    lvl_inv: mode_b_reg[BIT_LVL_INV], drive_en: mode_b_reg[BIT_DRIVE_EN]};

  ect_channel u_chan_a (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .ctrl_in       (ctrl_a),
    .ctrl_wr_in    (wr_mode_a_reg),
    .tick_in       (tick_a),
    .hit_in        (hit_a),
    .count_out     (count_a),
    .match_irq_out (irq_a),
    .wave_out      (wave_a)
  );

  ect_channel u_chan_b (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .ctrl_in       (ctrl_b),
    .ctrl_wr_in    (wr_mode_b_reg),
    .tick_in       (tick_b),
    .hit_in        (hit_b),
    .count_out     (count_b),
    .match_irq_out (irq_b),
    .wave_out      (wave_b)
  );

  // Cascade reports the sixteen-bit match on the upper channel only
  assign match_irq_a_out = irq_a && !cascade;
  assign match_irq_b_out = irq_b;

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Timer level ORs with the latch, so the latch must be zero to route it
  always_comb begin
    port_pin_out        = port_latch_in;
    port_pin_out[PIN_A] = port_latch_in[PIN_A] | (ctrl_a.drive_en & wave_a);
    port_pin_out[PIN_B] = port_latch_in[PIN_B] | (ctrl_b.drive_en & wave_b);
  end

  assign port_pin_oe_out = ~port_dir_reg;

endmodule : ect_timer
`default_nettype wire

// ### testbench/ect_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module ect_pulse_src (
  input  wire logic ref_clk_in,
  output logic      ev_out
);
  // ------------------------------------------------
  // Slow pulses so the input synchroniser sees each
  // ------------------------------------------------
  task automatic send(input int n);
    repeat (n) begin
      repeat (3) @(posedge ref_clk_in);
      #1 ev_out = 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1 ev_out = 1'b0;
    end
  endtask : send
  initial ev_out = 1'b0;
endmodule : ect_pulse_src
`default_nettype wire

// ### testbench/ect_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ect_timer_sva
  import ect_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [7:0]  port_latch_in,
  input wire logic [7:0]  port_pin_in,
  input wire logic [7:0]  port_pin_out,
  input wire logic [7:0]  port_pin_oe_out,
  input wire logic        match_irq_a_out,
  input wire logic        match_irq_b_out
);
  logic [7:0] mode_b_reg;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ------------------------------------------------
  // Shadow of mode control b, seen from the bus
  // ------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mode_b_reg <= 8'h00;
    end else if (reg_wr_in && reg_addr_in == ADDR_TMC_B) begin
      mode_b_reg <= reg_wdata_in;
    end
  end
  sequence s_wr(logic [15:0] a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  sequence s_rd(logic [15:0] a);
    reg_rd_in && !reg_wr_in && reg_addr_in == a;
  endsequence
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  AST_OE_DIR: assert property (s_wr(ADDR_PORT_DIR) |=> port_pin_oe_out == ~$past(reg_wdata_in))
    else $error("oe does not follow direction write");
  AST_DIR_RD: assert property (s_rd(ADDR_PORT_DIR) |=> reg_rdata_out == ~$past(port_pin_oe_out))
    else $error("direction read disagrees with oe");
  AST_RB_STROBE: assert property (s_rd(ADDR_TMC_B) |=> reg_rdata_out[3:2] == 2'b00)
    else $error("set or clear strobe read back nonzero");
  AST_RST_OE: assert property ($fell(sys_rst_in) |-> port_pin_oe_out == 8'h00)
    else $error("pins driven after reset");
  AST_RST_IRQ: assert property ($fell(sys_rst_in) |-> !match_irq_a_out && !match_irq_b_out)
    else $error("match pulse after reset");
  AST_PORT_PINS: assert property (port_pin_out[5:0] == port_latch_in[5:0])
    else $error("plain port pin not equal to latch");
  AST_DRIVE_OFF: assert property (!mode_b_reg[0] ##1 !mode_b_reg[0] |-> port_pin_out[7] == port_latch_in[7])
    else $error("timer reaches pin with drive off");
  AST_STOP_B: assert property ((!mode_b_reg[7] && !mode_b_reg[4]) [*3] |-> !match_irq_b_out)
    else $error("match pulse while stopped");
  AST_CASC_A: assert property (mode_b_reg[4] [*3] |-> !match_irq_a_out)
    else $error("first match pulse in cascade");
endmodule : ect_timer_sva
bind ect_timer ect_timer_sva i_ect_timer_sva (.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wr_in,
  .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .port_latch_in, .port_pin_in, .port_pin_out,
  .port_pin_oe_out, .match_irq_a_out, .match_irq_b_out);
`default_nettype wire

// ### testbench/test_ect_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_ect_timer
  import ect_pkg::*;
;
  logic             ref_clk_in;
  logic             sys_rst_in;
  logic [15:0]      reg_addr_in;
  logic             reg_wr_in;
  logic             reg_rd_in;
  logic [7:0]       reg_wdata_in;
  logic [7:0]       reg_rdata_out;
  logic [7:0]       port_latch_in;
  logic [5:0]       rnd_pins;
  logic             ev;
  wire logic [7:0]  port_pin_in = {ev, ev, rnd_pins};
  logic [7:0]       port_pin_out;
  logic [7:0]       port_pin_oe_out;
  logic             match_irq_a_out;
  logic             match_irq_b_out;
  logic [7:0]       d;
  logic             lv;
  int               n_fail;
  int               n_tests;
  int               seed;
  int               c;
  int               k;
  logic [7:0]       mdl [logic [15:0]];
  logic [15:0]      rst_addr [5] = '{ADDR_PORT_DIR, ADDR_TMC_B, ADDR_CMP_B, ADDR_TCL_B, 16'h0000};
  ect_timer i_ect_timer (.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .port_latch_in, .port_pin_in, .port_pin_out,
    .port_pin_oe_out, .match_irq_a_out, .match_irq_b_out);
  ect_pulse_src i_ect_pulse_src (.ref_clk_in, .ev_out(ev));
  // ------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    port_latch_in = {2'b00, 6'($random(seed))};
    rnd_pins = 6'($random(seed));
    @(posedge ref_clk_in);
    #1 reg_wr_in = 1'b0;
    mdl[a] = v & ((a == ADDR_TMC_B) ? TMC_B_RD_MASK : (a == ADDR_TMC_A) ? TMC_A_RD_MASK :
                  (a == ADDR_TCL_A || a == ADDR_TCL_B) ? TCL_MASK : 8'hFF);
    @(posedge ref_clk_in);
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(posedge ref_clk_in);
    #1 reg_rd_in = 1'b0;
    @(posedge ref_clk_in);
    #1 v = reg_rdata_out;
  endtask : rd
  task automatic rdchk(input logic [15:0] a);
    logic [7:0] v;
    rd(a, v);
    chk("reg", 32'(mdl.exists(a) ? mdl[a] : 8'h00), 32'(v));
  endtask : rdchk
  // Bounded wait, always steps at least one cycle
  task automatic wirq();
    c = 0;
    do begin
      @(posedge ref_clk_in);
      #1 c++;
    end while (match_irq_b_out !== 1'b1 && c < 9000);
    chk("irq_wait", 1, match_irq_b_out);
  endtask : wirq
  task automatic ival(input logic [2:0] sel, input logic [7:0] n, input int dv);
    wr(ADDR_TMC_B, 8'h00);
    wr(ADDR_CMP_B, n);
    wr(ADDR_TCL_B, {5'h00, sel});
    wr(ADDR_TMC_B, 8'h80);
    wirq();
    wirq();
    chk("interval", (n + 1) * dv, c);
  endtask : ival
  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------
  // Clock, watchdog, main sequence
  // ------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #1ms;
    n_fail++;
    finish_test();
  end
  initial begin
    {reg_addr_in, reg_wr_in, reg_rd_in, reg_wdata_in, port_latch_in, rnd_pins} = '0;
    seed = 56530;
    n_fail = 0;
    n_tests = 0;
    mdl[ADDR_PORT_DIR] = RST_PORT_DIR;
    sys_rst_in = 1'b1;
    repeat (6) @(posedge ref_clk_in);
    #1 sys_rst_in = 1'b0;
    foreach (rst_addr[i]) begin
      rdchk(rst_addr[i]);
    end
    ival(SEL_DIV1, 8'h00, 1);
    ival(SEL_DIV2, 8'($random(seed)), 2);
    ival(SEL_DIV8, 8'h02, 8);
    ival(SEL_DIV32, 8'h01, 32);
    ival(SEL_DIV128, 8'h01, 128);
    ival(SEL_TOP, 8'h00, 4096);
    ival(SEL_DIV1, 8'hFF, 1);
    repeat (100) @(posedge ref_clk_in);
    #1 wr(ADDR_CMP_B, 8'h10);
    wirq();
    chk("wrap", 1, c > 100);
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TMC_A, 8'h00);
      wr(ADDR_TMC_B, 8'h00);
      wr(ADDR_CMP_A, 8'hFF);
      wr(ADDR_CMP_B, 8'hFF);
      wr(ADDR_TCL_A, {5'h00, s ? SEL_EXT_RISE : SEL_EXT_FALL});
      wr(ADDR_TCL_B, {5'h00, s ? SEL_EXT_RISE : SEL_EXT_FALL});
      wr(ADDR_TMC_A, 8'h80);
      wr(ADDR_TMC_B, 8'h80);
      k = 1 + ($unsigned($random(seed)) % 16);
      i_ect_pulse_src.send(k);
      repeat (5) @(posedge ref_clk_in);
      #1 rd(ADDR_CNT_B, d);
      chk("events", k, d);
      rd(ADDR_CNT_A, d);
      chk("events_a", k, d);
      wr(ADDR_TMC_A, 8'h00);
      wr(ADDR_TMC_B, 8'h00);
      rd(ADDR_CNT_B, d);
      chk("stopped", 0, d);
    end
    wr(ADDR_PORT_DIR, 8'h3F);
    chk("oe", 8'hC0, port_pin_oe_out);
    rdchk(ADDR_PORT_DIR);
    wr(ADDR_TMC_B, 8'h09);
    chk("pin_set", 1, port_pin_out[7]);
    rdchk(ADDR_TMC_B);
    wr(ADDR_TMC_B, 8'h01);
    chk("pin_hold", 1, port_pin_out[7]);
    wr(ADDR_TMC_B, 8'h05);
    chk("pin_clr", 0, port_pin_out[7]);
    wr(ADDR_TMC_B, 8'h00);
    wr(ADDR_CMP_B, 8'h03);
    wr(ADDR_TCL_B, {5'h00, SEL_DIV1});
    wr(ADDR_TMC_B, 8'h83);
    lv = 1'b0;
    repeat (4) begin
      wirq();
      lv = ~lv;
      chk("toggle", lv, port_pin_out[7]);
    end
    wr(ADDR_TMC_B, 8'h00);
    wr(ADDR_TMC_B, 8'h81);
    repeat (3) wirq();
    chk("no_toggle", lv, port_pin_out[7]);
    // PWM: active from overflow up to and including the match tick
    d = {1'b0, 7'($random(seed))};
    wr(ADDR_TMC_B, 8'h00);
    wr(ADDR_CMP_B, d);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_TMC_B, p ? 8'hC3 : 8'hC1);
      wirq();
      k = 0;
      repeat (256) begin
        @(posedge ref_clk_in);
        #1 k += port_pin_out[7];
      end
      chk("pwm_active", p ? 255 - d : d + 1, k);
      wr(ADDR_TMC_B, 8'h00);
    end
    wr(ADDR_TMC_B, 8'h41);
    chk("pwm_stop", 0, port_pin_out[7]);
    wr(ADDR_CMP_A, 8'h00);
    wr(ADDR_TCL_A, {5'h00, SEL_DIV1});
    wr(ADDR_TMC_A, 8'h80);
    chk("irq_a", 1, match_irq_a_out);
    wr(ADDR_TMC_B, 8'h00);
    wr(ADDR_TMC_B, 8'h10);
    repeat (5) @(posedge ref_clk_in);
    #1 chk("casc_a", 0, match_irq_a_out);
    wr(ADDR_TMC_A, 8'h00);
    wr(ADDR_TMC_B, 8'h00);
    wr(ADDR_CMP_A, 8'h02);
    wr(ADDR_CMP_B, 8'h01);
    wr(ADDR_TMC_B, 8'h90);
    wr(ADDR_TMC_A, 8'h80);
    wirq();
    wirq();
    chk("casc_ival", 259, c);
    wr(ADDR_TMC_A, 8'h00);
    wr(ADDR_TMC_A, 8'h09);
    chk("pin_a_set", 1, port_pin_out[6]);
    sys_rst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 sys_rst_in = 1'b0;
    mdl.delete();
    mdl[ADDR_PORT_DIR] = RST_PORT_DIR;
    rdchk(ADDR_TMC_B);
    rdchk(ADDR_PORT_DIR);
    finish_test();
  end
endmodule : test_ect_timer
`default_nettype wire
